// [src/tacc_defines.svh]
// Offsets, field positions, reset values and timing figures of the block.
// Function
// R1 - Skip count N discards N sequences per one admitted; zero admits all.
// R2 - Full power: calibration held off hold count times 16 sequences.
// R3 - Low power: calibration held off hold count times 4 sequences.
// R4 - Full-to-low timeout is hold count times 1.25, 1.50, 1.75 or 2.00.
// R5 - Forced calibration bit set makes every stage recalibrate.
// R6 - Writing sequence restart returns to first stage; the bit self-clears.
// R7 - Ten-bit full power near recalibration time, default 3ff.
// R8 - Six-bit low power near recalibration time, default 3f.
// R9 - Twelve stage low enables gate low-threshold sources onto interrupt.
// R10 - Pin setup: 00 off, 01 input, 10 active-low out, 11 active-high out.
// R11 - Input trigger: 00 low level, 01 rising, 10 falling, 11 high level.
// R12 - Pin interrupt enable lets qualifying pin input events raise interrupt.
// R13 - Per-stage low limit status bit sets when low threshold exceeded.
// R14 - Interrupt asserted while any enabled low limit status bit is set.
`ifndef TACC_DEFINES_SVH
`define TACC_DEFINES_SVH

// Register offsets on the serial register port.
`define TACC_OFS_CTRL_A 10'h002
`define TACC_OFS_CTRL_B 10'h003
`define TACC_OFS_RECAL 10'h004
`define TACC_OFS_LOW_EN 10'h005
`define TACC_OFS_DONE_EN 10'h007
`define TACC_OFS_LOW_STAT 10'h008

// Field positions in ambient_comp_control_a.
`define TACC_SKIP_LSB 0
`define TACC_FP_HOLD_LSB 4
`define TACC_LP_HOLD_LSB 8
`define TACC_TMO_LSB 12
`define TACC_FORCE_BIT 14
`define TACC_RESTART_BIT 15

// Field positions in proximity_recal_time and the two enable registers.
`define TACC_LP_RECAL_LSB 10
`define TACC_PIN_SETUP_LSB 12
`define TACC_PIN_TRIG_LSB 14
`define TACC_PIN_IRQ_BIT 12

// Reset values.
`define TACC_RST_CTRL_A 16'h0ff0
`define TACC_RST_CTRL_B 16'h0164
`define TACC_RST_RECAL 16'hffff
`define TACC_RST_ZERO 16'h0000

// Sequence multipliers for the hold-off periods, and the timeout base.
`define TACC_FP_HOLD_MULT 16
`define TACC_LP_HOLD_MULT 4
`define TACC_TMO_QUARTERS_BASE 5

`endif

// [src/tacc_pkg.sv]
// Types shared by the ambient compensation control registers.
package tacc_pkg;

  // Power mode of the conversion engine.
  typedef enum logic {
    TACC_PWR_FULL,
    TACC_PWR_LOW
  } tacc_power_type;

  // General purpose pin setup codes.
  typedef enum logic [1:0] {
    TACC_PIN_OFF = 2'h0,
    TACC_PIN_IN = 2'h1,
    TACC_PIN_OUT_LOW = 2'h2,
    TACC_PIN_OUT_HIGH = 2'h3
  } tacc_pin_type;

endpackage : tacc_pkg

// [src/tacc_seq_timer.sv]
// Loadable down-counter that runs in whole conversion sequences.
module tacc_seq_timer #(
  parameter int WIDTH = 10
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Control.
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic seq_tick,
  // Status.
  output logic busy_reg,
  output logic expire_reg
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire last_tick = seq_tick && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});

  // Load wins over the tick so a fresh event always restarts the period.
  assign count_next = load ? load_value :
                      (seq_tick && busy_reg) ? count_reg - 1'b1 : count_reg;

  // The counter stops at zero; a zero load value means no period at all.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      expire_reg <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      busy_reg <= (count_next != '0);
      expire_reg <= !load && busy_reg && last_tick;
    end
  end

endmodule : tacc_seq_timer

// [src/tacc_ctrl_regs.sv]
// Ambient compensation control registers and their sequencing logic.
`include "tacc_defines.svh"

module tacc_ctrl_regs #(
  parameter int STAGES = 12,
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port from the serial interface decoder.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_reg,
  output logic reg_rvalid_reg,
  // Conversion engine events.
  input wire logic seq_done,
  input wire logic near_active,
  input wire logic [STAGES-1:0] stage_low_hit,
  // Conversion engine controls.
  output logic fifo_admit_reg,
  output logic cal_suspend_reg,
  output logic low_power_reg,
  output logic force_cal_reg,
  output logic seq_restart_reg,
  output logic near_recal_req_reg,
  output logic [7:0] near_recal_level_reg,
  output logic [1:0] slow_filter_step_level_reg,
  // Interrupt pin, active low.
  output logic irq_n_reg,
  // General purpose pin.
  input wire logic gpio_in,
  output logic gpio_out_reg,
  output logic gpio_oe_n_reg
);

  // Register storage.
  logic [DATA_W-1:0] ctrl_a_reg;
  logic [DATA_W-1:0] ctrl_b_reg;
  logic [DATA_W-1:0] recal_reg;
  logic [DATA_W-1:0] low_en_reg;
  logic pin_irq_en_reg;
  logic [STAGES-1:0] low_stat_reg;
  logic pin_event_reg;
  logic gpio_prev_reg;
  logic [3:0] skip_cnt_reg;
  logic [9:0] near_cnt_reg;
  tacc_pkg::tacc_power_type power_reg;
  tacc_pkg::tacc_power_type power_next;

  // Address decode.
  wire wr_a = reg_wr && (reg_addr == `TACC_OFS_CTRL_A);
  wire wr_b = reg_wr && (reg_addr == `TACC_OFS_CTRL_B);
  wire wr_recal = reg_wr && (reg_addr == `TACC_OFS_RECAL);
  wire wr_low_en = reg_wr && (reg_addr == `TACC_OFS_LOW_EN);
  wire wr_done_en = reg_wr && (reg_addr == `TACC_OFS_DONE_EN);
  wire rd_stat = reg_rd && (reg_addr == `TACC_OFS_LOW_STAT);

  // Field extraction.
  wire [3:0] fast_filter_skip_count = ctrl_a_reg[`TACC_SKIP_LSB +: 4];
  wire [3:0] full_power_cal_hold_count = ctrl_a_reg[`TACC_FP_HOLD_LSB +: 4];
  wire [3:0] low_power_cal_hold_count = ctrl_a_reg[`TACC_LP_HOLD_LSB +: 4];
  wire [1:0] power_drop_timeout_select = ctrl_a_reg[`TACC_TMO_LSB +: 2];
  wire [9:0] full_power_near_recal_time = recal_reg[9:0];
  wire [5:0] low_power_near_recal_time = recal_reg[`TACC_LP_RECAL_LSB +: 6];
  wire [STAGES-1:0] stage_low_irq_enable = low_en_reg[STAGES-1:0];
  wire [1:0] pin_setup = low_en_reg[`TACC_PIN_SETUP_LSB +: 2];
  wire [1:0] pin_trigger = low_en_reg[`TACC_PIN_TRIG_LSB +: 2];

  // Hold-off period in sequences, scaled by the active power mode.
  function automatic logic [9:0] hold_sequences(
    input tacc_pkg::tacc_power_type mode,
    input logic [3:0] fp_count,
    input logic [3:0] lp_count
  );
    logic [9:0] fp_seq;
    logic [9:0] lp_seq;
    fp_seq = 10'({fp_count, 4'h0});
    lp_seq = 10'({lp_count, 2'h0});
    hold_sequences = (mode == tacc_pkg::TACC_PWR_LOW) ? lp_seq : fp_seq;
  endfunction : hold_sequences

  // Timeout = hold count x 16 sequences x (5 + select) / 4.
  function automatic logic [9:0] timeout_sequences(
    input logic [3:0] fp_count,
    input logic [1:0] sel
  );
    logic [9:0] quarters;
    // Ten-bit operands: select 11 gives eight quarters, and 15 x 4 x 8 needs 9 bits.
    quarters = 10'(`TACC_TMO_QUARTERS_BASE) + {8'h00, sel};
    timeout_sequences = {4'h0, fp_count, 2'h0} * quarters;
  endfunction : timeout_sequences

  // Write side of the control registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= `TACC_RST_CTRL_A;
      ctrl_b_reg <= `TACC_RST_CTRL_B;
      recal_reg <= `TACC_RST_RECAL; // [R7] [R8]
      low_en_reg <= `TACC_RST_ZERO;
      pin_irq_en_reg <= 1'b0;
    end else if (ce) begin
      if (wr_a) begin
        ctrl_a_reg <= reg_wdata & ~(16'h1 << `TACC_RESTART_BIT); // [R6]
      end
      if (wr_b) begin
        ctrl_b_reg <= reg_wdata;
      end
      if (wr_recal) begin
        recal_reg <= reg_wdata;
      end
      if (wr_low_en) begin
        low_en_reg <= reg_wdata;
      end
      if (wr_done_en) begin
        pin_irq_en_reg <= reg_wdata[`TACC_PIN_IRQ_BIT]; // [R12]
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == `TACC_OFS_CTRL_A) ? ctrl_a_reg :
    (reg_addr == `TACC_OFS_CTRL_B) ? ctrl_b_reg :
    (reg_addr == `TACC_OFS_RECAL) ? recal_reg :
    (reg_addr == `TACC_OFS_LOW_EN) ? low_en_reg :
    (reg_addr == `TACC_OFS_DONE_EN) ?
      DATA_W'({pin_irq_en_reg, 12'h000}) :
    (reg_addr == `TACC_OFS_LOW_STAT) ?
      DATA_W'({pin_event_reg, low_stat_reg}) : // [R13]
    '0;

  // Read data is registered and answers one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= '0;
      reg_rvalid_reg <= 1'b0;
    end else if (ce) begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rd_mux;
      end
    end
  end

  // Fast filter admission: admit one sequence, then discard N.
  wire skip_wrap = (skip_cnt_reg >= fast_filter_skip_count);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      skip_cnt_reg <= 4'h0;
      fifo_admit_reg <= 1'b0;
    end else if (ce) begin
      fifo_admit_reg <= seq_done && skip_cnt_reg == 4'h0; // [R1]
      if (seq_restart_reg) begin
        skip_cnt_reg <= 4'h0;
      end else if (seq_done) begin
        skip_cnt_reg <= skip_wrap ? 4'h0 : skip_cnt_reg + 4'h1; // [R1]
      end
    end
  end

  // Calibration hold-off restarts on every sequence that sees proximity.
  wire near_seq = seq_done && near_active;
  wire hold_busy;
  wire tmo_expire;
  wire [9:0] hold_len = hold_sequences(power_reg,
                                       full_power_cal_hold_count,
                                       low_power_cal_hold_count); // [R2] [R3]
  tacc_seq_timer #(.WIDTH(10)) u_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(near_seq),
    .load_value(hold_len),
    .seq_tick(seq_done && !near_active),
    .busy_reg(hold_busy),
    .expire_reg()
  );

  // Full power idle timeout; any proximity sequence reloads it.
  wire tmo_running;
  wire tmo_load = (near_seq || power_reg == tacc_pkg::TACC_PWR_LOW) ||
                  (seq_done && !tmo_running);
  tacc_seq_timer #(.WIDTH(10)) u_timeout (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(tmo_load && !(tmo_running && !near_seq &&
          power_reg == tacc_pkg::TACC_PWR_FULL)),
    .load_value(timeout_sequences(full_power_cal_hold_count,
                                  power_drop_timeout_select)), // [R4]
    .seq_tick(seq_done),
    .busy_reg(tmo_running),
    .expire_reg(tmo_expire)
  );

  // Power mode: proximity wakes to full power, the timeout drops to low.
  always_comb begin
    case (power_reg)
      tacc_pkg::TACC_PWR_FULL: begin
        power_next = tmo_expire ? tacc_pkg::TACC_PWR_LOW
                                : tacc_pkg::TACC_PWR_FULL; // [R4]
      end
      tacc_pkg::TACC_PWR_LOW: begin
        power_next = near_seq ? tacc_pkg::TACC_PWR_FULL
                              : tacc_pkg::TACC_PWR_LOW;
      end
      default: begin
        power_next = tacc_pkg::TACC_PWR_FULL;
      end
    endcase
  end

  // Near recalibration: proximity persisting past the time forces recal.
  wire [9:0] near_limit = (power_reg == tacc_pkg::TACC_PWR_LOW) ?
    {4'h0, low_power_near_recal_time} : full_power_near_recal_time;
  wire near_hit = near_seq && (near_cnt_reg >= near_limit); // [R7] [R8]

  // Mode, proximity counter and conversion engine controls.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= tacc_pkg::TACC_PWR_FULL;
      near_cnt_reg <= 10'h000;
      near_recal_req_reg <= 1'b0;
      low_power_reg <= 1'b0;
      cal_suspend_reg <= 1'b0;
      force_cal_reg <= 1'b0;
      seq_restart_reg <= 1'b0;
      near_recal_level_reg <= 8'h00;
      slow_filter_step_level_reg <= 2'h0;
    end else if (ce) begin
      power_reg <= power_next;
      low_power_reg <= (power_next == tacc_pkg::TACC_PWR_LOW);
      cal_suspend_reg <= hold_busy; // [R2] [R3]
      force_cal_reg <= ctrl_a_reg[`TACC_FORCE_BIT]; // [R5]
      seq_restart_reg <= wr_a && reg_wdata[`TACC_RESTART_BIT]; // [R6]
      near_recal_level_reg <= ctrl_b_reg[7:0];
      slow_filter_step_level_reg <= ctrl_b_reg[15:14];
      near_recal_req_reg <= near_hit;
      if (seq_done && !near_active) begin
        near_cnt_reg <= 10'h000;
      end else if (near_seq) begin
        near_cnt_reg <= near_hit ? 10'h000 : near_cnt_reg + 10'h001;
      end
    end
  end

  // Pin input trigger decode.
  wire pin_is_input = (pin_setup == tacc_pkg::TACC_PIN_IN); // [R10]
  wire pin_trig =
    (pin_trigger == 2'h0) ? !gpio_in :
    (pin_trigger == 2'h1) ? (gpio_in && !gpio_prev_reg) :
    (pin_trigger == 2'h2) ? (!gpio_in && gpio_prev_reg) :
    gpio_in; // [R11]
  wire pin_set = pin_is_input && pin_trig;

  // Status flags: a new event in the read cycle wins over the clear.
  wire [STAGES-1:0] low_stat_next =
    (rd_stat ? '0 : low_stat_reg) | stage_low_hit; // [R13]
  wire pin_event_next = (rd_stat ? 1'b0 : pin_event_reg) | pin_set;
  wire irq_any = |(low_stat_next & stage_low_irq_enable) ||
                 (pin_event_next && pin_irq_en_reg); // [R9] [R12] [R14]

  // Status, interrupt pin and general purpose pin drive.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_stat_reg <= '0;
      pin_event_reg <= 1'b0;
      gpio_prev_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      gpio_out_reg <= 1'b0;
      gpio_oe_n_reg <= 1'b1;
    end else if (ce) begin
      low_stat_reg <= low_stat_next;
      pin_event_reg <= pin_event_next;
      gpio_prev_reg <= gpio_in;
      irq_n_reg <= !irq_any; // [R14]
      gpio_oe_n_reg <= !pin_setup[1]; // [R10]
      gpio_out_reg <= (pin_setup == tacc_pkg::TACC_PIN_OUT_HIGH) ?
                      irq_any : !irq_any; // [R10]
    end
  end

endmodule : tacc_ctrl_regs

// [bench/tacc_ctrl_regs_chk.sv]
// Port-level assertions for the ambient compensation control registers.
`include "tacc_defines.svh"

module tacc_ctrl_regs_chk #(
  parameter int STAGES = 12
) (
  // Clock, reset and register port.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid_reg,
  // Engine events and controls.
  input wire logic seq_done,
  input wire logic [STAGES-1:0] stage_low_hit,
  input wire logic fifo_admit_reg,
  input wire logic force_cal_reg,
  input wire logic seq_restart_reg,
  // Interrupt and pin.
  input wire logic irq_n_reg,
  input wire logic gpio_oe_n_reg
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic wr_a;
  logic wr_e;
  logic [STAGES-1:0] en_reg;
  // Write decodes for the control word and the enable register.
  assign wr_a = ce && reg_wr && reg_addr == `TACC_OFS_CTRL_A;
  assign wr_e = ce && reg_wr && reg_addr == `TACC_OFS_LOW_EN;

  // Shadow of the stage enables; a hit is judged against the old value.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_reg <= '0;
    else if (wr_e) en_reg <= reg_wdata[STAGES-1:0];
  end

  // A read is answered on the next edge, and only a read is answered.
  read_answer_a: assert property (ce && reg_rd |=> reg_rvalid_reg)
    else $error("read without answer");
  answer_cause_a: assert property (reg_rvalid_reg |-> $past(reg_rd))
    else $error("answer without read");
  restart_pulse_a: assert property (
    wr_a && reg_wdata[15] |=> seq_restart_reg ##1 !seq_restart_reg)
    else $error("restart is not a single pulse");
  force_copy_a: assert property (
    wr_a ##1 !reg_wr |=> force_cal_reg == $past(reg_wdata[14], 2))
    else $error("forced calibration output wrong");
  pin_drive_a: assert property (
    wr_e ##1 !reg_wr |=> gpio_oe_n_reg == !$past(reg_wdata[13], 2))
    else $error("pin drive enable wrong");
  // The interrupt follows an enabled hit and holds until a read or a write ends it.
  irq_assert_a: assert property (
    ce && |(stage_low_hit & en_reg) |=> !irq_n_reg)
    else $error("enabled hit gave no interrupt");
  irq_hold_a: assert property (
    !irq_n_reg && !reg_rd && !reg_wr |=> !irq_n_reg)
    else $error("interrupt released without a read");
  admit_cause_a: assert property (fifo_admit_reg |-> $past(seq_done))
    else $error("admit without a finished sequence");
endmodule : tacc_ctrl_regs_chk

bind tacc_ctrl_regs tacc_ctrl_regs_chk #(.STAGES(STAGES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid_reg(reg_rvalid_reg), .seq_done(seq_done),
  .stage_low_hit(stage_low_hit), .fifo_admit_reg(fifo_admit_reg),
  .force_cal_reg(force_cal_reg), .seq_restart_reg(seq_restart_reg),
  .irq_n_reg(irq_n_reg), .gpio_oe_n_reg(gpio_oe_n_reg));

// [bench/tacc_host_model.sv]
// Host model that writes and reads the block's registers.
module tacc_host_model (
  // Clock.
  input wire logic clk_sys,
  // Request.
  output logic [9:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  // Answer.
  input wire logic [15:0] reg_rdata_reg,
  input wire logic reg_rvalid_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One request for one cycle; the idle bus then shows inverted values,
  // so nothing can lean on a stale address or data word.
  task automatic req(input logic w, input logic [9:0] a,
                     input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : req

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    req(1'b1, a, d);
  endtask : wr

  // The answer is due one edge after the request is taken.
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    req(1'b0, a, 16'h0000);
    @(posedge clk_sys);
    d = (reg_rvalid_reg === 1'b1) ? reg_rdata_reg : 'x;
  endtask : rd
endmodule : tacc_host_model

// [bench/testbench.sv]
// Self-checking bench for the ambient compensation control registers.
`include "tacc_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, ce, seq_done, near_active, gpio_in, idle_v;
  logic reg_wr, reg_rd, reg_rvalid_reg, fifo_admit_reg, cal_suspend_reg;
  logic low_power_reg, force_cal_reg, seq_restart_reg, irq_n_reg;
  logic gpio_out_reg, gpio_oe_n_reg;
  logic [11:0] stage_low_hit, en_v, hit_v;
  logic [9:0] reg_addr, a_v;
  logic [15:0] reg_wdata, reg_rdata_reg, rd_v, wd_v;
  logic [25:0] rst_tab [7];
  logic [3:0] skip_tab [4];
  logic [7:0] lvl_v;
  logic [1:0] sfl_v;
  int miscompares = 0, checks_done = 0, cycles = 0, admits = 0;
  integer seed = 95805;

  tacc_ctrl_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
    .reg_rvalid_reg(reg_rvalid_reg), .seq_done(seq_done),
    .near_active(near_active), .stage_low_hit(stage_low_hit),
    .fifo_admit_reg(fifo_admit_reg), .cal_suspend_reg(cal_suspend_reg),
    .low_power_reg(low_power_reg), .force_cal_reg(force_cal_reg),
    .seq_restart_reg(seq_restart_reg), .near_recal_req_reg(),
    .near_recal_level_reg(lvl_v), .slow_filter_step_level_reg(sfl_v),
    .irq_n_reg(irq_n_reg), .gpio_in(gpio_in),
    .gpio_out_reg(gpio_out_reg), .gpio_oe_n_reg(gpio_oe_n_reg));
  tacc_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Four-state compare, so an unknown never passes for a match.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Quiet sequences before the power drop, hold count one.
  function automatic int tmo_seqs(input int c);
    return `TACC_FP_HOLD_MULT * (`TACC_TMO_QUARTERS_BASE + c) / 4;
  endfunction : tmo_seqs

  // Sequence completions four cycles apart, proximity as given.
  task automatic seqs(input int n, input logic nr);
    repeat (n) begin
      @(posedge clk_sys);
      seq_done <= 1'b1;
      near_active <= nr;
      @(posedge clk_sys);
      seq_done <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : seqs

  // Cycle ceiling, far above the eleven hundred or so cycles the run needs.
  always @(posedge clk_sys) begin
    cycles++;
    if (fifo_admit_reg === 1'b1) admits++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    seq_done = 1'b0;
    near_active = 1'b0;
    gpio_in = 1'b1;
    stage_low_hit = 12'h000;
    rst_tab = '{{`TACC_OFS_CTRL_A, `TACC_RST_CTRL_A},
      {`TACC_OFS_CTRL_B, `TACC_RST_CTRL_B}, {`TACC_OFS_RECAL, 16'hffff},
      {`TACC_OFS_LOW_EN, 16'h0}, {`TACC_OFS_DONE_EN, 16'h0},
      {`TACC_OFS_LOW_STAT, 16'h0}, {10'h00a, 16'h0}};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rst_tab[i]) begin
      u_host.rd(rst_tab[i][25:16], rd_v);
      chk(rd_v, rst_tab[i][15:0]);
    end
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      a_v = 10'h003 + 10'(i % 3);
      wd_v = 16'($random(seed));
      u_host.wr(a_v, wd_v);
      u_host.rd(a_v, rd_v);
      chk(rd_v, wd_v);
      if (i % 3 == 0) chk({6'h0, sfl_v, lvl_v}, {6'h0, wd_v[15:14], wd_v[7:0]});
    end
    u_host.wr(`TACC_OFS_LOW_EN, 16'h0000);
    u_host.rd(`TACC_OFS_LOW_STAT, rd_v);
    $display("read back done");
    // Restart clears the skip phase, so N+1 sequences give one admit.
    skip_tab = '{4'h0, 4'h1, 4'hb, 4'({$random(seed)} % 12)};
    foreach (skip_tab[i]) begin
      wd_v = 16'h8ff0 | {12'h000, skip_tab[i]};
      u_host.wr(`TACC_OFS_CTRL_A, wd_v);
      u_host.rd(`TACC_OFS_CTRL_A, rd_v);
      chk(rd_v, wd_v & 16'h7fff);
      admits = 0;
      seqs(3 * (skip_tab[i] + 1), 1'b0);
      chk(16'(admits), 16'h0003);
    end
    $display("skip done");
    u_host.wr(`TACC_OFS_CTRL_A, 16'h7f20);
    repeat (2) @(posedge clk_sys);
    chk({15'h0, force_cal_reg}, 16'h0001);
    seqs(2, 1'b1);
    chk({15'h0, cal_suspend_reg}, 16'h0001);
    seqs(2 * `TACC_FP_HOLD_MULT - 1, 1'b0);
    chk({15'h0, cal_suspend_reg}, 16'h0001);
    seqs(1, 1'b0);
    chk({15'h0, cal_suspend_reg}, 16'h0000);
    $display("hold-off done");
    for (int c = 0; c < 4; c++) begin
      u_host.wr(`TACC_OFS_CTRL_A, 16'h0f10 | 16'(c << 12));
      seqs(2, 1'b1);
      seqs(tmo_seqs(c) - 1, 1'b0);
      chk({15'h0, low_power_reg}, 16'h0000);
      chk({15'h0, force_cal_reg}, 16'h0000);
      seqs(2, 1'b0);
      chk({15'h0, low_power_reg}, 16'h0001);
    end
    $display("timeout done");
    for (int i = 0; i < 6; i++) begin
      en_v = (i == 0) ? 12'h800 : (i == 1) ? 12'h000 : 12'($random(seed));
      hit_v = (i < 2) ? 12'h800 : 12'($random(seed));
      u_host.wr(`TACC_OFS_LOW_EN, {4'h0, en_v});
      stage_low_hit <= hit_v;
      @(posedge clk_sys);
      stage_low_hit <= 12'h000;
      repeat (2) @(posedge clk_sys);
      chk({15'h0, irq_n_reg}, {15'h0, (hit_v & en_v) == 12'h000});
      u_host.rd(`TACC_OFS_LOW_STAT, rd_v);
      chk(rd_v, {4'h0, hit_v});
      @(posedge clk_sys);
      chk({15'h0, irq_n_reg}, 16'h0001);
    end
    $display("interrupt done");
    for (int s = 0; s < 4; s++) begin
      u_host.wr(`TACC_OFS_LOW_EN, {4'(s), 12'h000});
      repeat (2) @(posedge clk_sys);
      chk({15'h0, gpio_oe_n_reg}, {15'h0, s < 2});
      if (s >= 2) chk({15'h0, gpio_out_reg}, {15'h0, s == 2});
    end
    $display("pin setup done");
    // Each trigger starts from the level that must not fire it.
    u_host.wr(`TACC_OFS_DONE_EN, 16'h1000);
    for (int t = 0; t < 4; t++) begin
      idle_v = (t == 0 || t == 2);
      gpio_in <= idle_v;
      u_host.wr(`TACC_OFS_LOW_EN, {2'(t), 14'h1000});
      repeat (2) u_host.rd(`TACC_OFS_LOW_STAT, rd_v);
      chk(rd_v, 16'h0000);
      gpio_in <= !idle_v;
      repeat (3) @(posedge clk_sys);
      chk({15'h0, irq_n_reg}, 16'h0000);
      u_host.rd(`TACC_OFS_LOW_STAT, rd_v);
      chk(rd_v, 16'h1000);
    end
    $display("pin trigger done");
    report_and_stop();
  end
endmodule : testbench
